// ===== design/tpo_regs.svh
/*
 Register indices, field positions and reset values of the timer pin output block.
 Assumes word addressing on the Avalon-MM slave: the byte address is four times the index.
*/
`ifndef TPO_REGS_SVH
`define TPO_REGS_SVH

`define TPO_CNT_W 16
`define TPO_NPIN 4
`define TPO_NCH 2
`define TPO_ADDR_W 6
`define TPO_DATA_W 32

`define TPO_IDX_START_A 6'h00
`define TPO_IDX_START 6'h01
`define TPO_IDX_MODE 6'h02
`define TPO_IDX_OCR_FIRST 6'h03
`define TPO_IDX_OCR_SECOND 6'h04
`define TPO_IDX_IOC0 6'h05
`define TPO_IDX_IOC1 6'h06
`define TPO_IDX_GCA0 6'h07
`define TPO_IDX_GCA1 6'h08
`define TPO_IDX_PERIOD 6'h09
`define TPO_IDX_CNT0 6'h0a
`define TPO_IDX_CNT1 6'h0b
`define TPO_IDX_DEAD 6'h0c
`define TPO_IDX_HIZ_FIRST 6'h0d
`define TPO_IDX_HIZ_SECOND 6'h0e
`define TPO_IDX_PFS 6'h0f
`define TPO_IDX_GPIO 6'h10
`define TPO_IDX_STATUS 6'h11
`define TPO_IDX_ADCA 6'h12
`define TPO_IDX_ADCB 6'h13

`define TPO_MODE_MSB 1
`define TPO_IOC_INIT_BIT 0
`define TPO_IOC_ACT_LSB 1
`define TPO_IOC_ACT_MSB 2
`define TPO_OCR_SEL_BIT 7
`define TPO_HIZ_EN_BIT 0
`define TPO_ST_HIZ_BIT 0
`define TPO_ST_LVL0_BIT 1
`define TPO_ST_LVL1_BIT 2

`define TPO_PERIOD_RST 16'hffff
`define TPO_DEAD_RST 16'h0010
`define TPO_PFS_RST 4'hf

`endif

// ===== design/tpo_pkg.sv
/*
 Types shared by the timer pin output block.
 Assumes tpo_regs.svh is on the include path.
*/
`include "tpo_regs.svh"

package tpo_pkg;
   typedef logic [`TPO_CNT_W-1:0] tpo_cnt_t;
   typedef logic [`TPO_DATA_W-1:0] tpo_word_t;
   typedef enum logic [1:0] {TPO_MODE_NORMAL, TPO_MODE_COMP, TPO_MODE_RSYNC, TPO_MODE_RSVD}
      tpo_mode_t;
   typedef enum logic [1:0] {TPO_ACT_NONE, TPO_ACT_LOW, TPO_ACT_HIGH, TPO_ACT_TOGGLE} tpo_act_t;
endpackage : tpo_pkg

// ===== design/tpo_chan_if.sv
/*
 Signals between the register side and one channel counter.
 Assumes tpo_pkg is compiled first.
*/
`timescale 1ns/1ps

interface tpo_chan_if;
   import tpo_pkg::*;
   logic run;
   logic pwm_mode;
   logic halt_level;
   logic io_load;
   logic io_init;
   tpo_act_t io_act;
   tpo_cnt_t cmp_a;
   tpo_cnt_t period;
   tpo_cnt_t ext_cnt;
   tpo_cnt_t sub_cnt;
   logic use_ext;
   tpo_cnt_t count;
   logic level;
   logic match_a;
   modport ctrl (output run, pwm_mode, halt_level, io_load, io_init, io_act, cmp_a, period,
      ext_cnt, sub_cnt, use_ext, input count, level, match_a);
   modport chan (input run, pwm_mode, halt_level, io_load, io_init, io_act, cmp_a, period,
      ext_cnt, sub_cnt, use_ext, output count, level, match_a);
endinterface : tpo_chan_if

// ===== design/tpo_chan.sv
/*
 One channel: up counter, compare-A match and output pin level.
 Assumes the control side drives all settings on the same clock, from registers except io_load and io_init, which come from the bus write.
*/
`timescale 1ns/1ps

module tpo_chan
   import tpo_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   tpo_chan_if.chan cif
);
   logic run_q_ff;
   tpo_cnt_t count_ff;
   logic level_ff;
   logic match;

   assign match = cif.run & ((count_ff == cif.cmp_a) |
      (cif.use_ext & ((cif.ext_cnt == cif.cmp_a) | (cif.sub_cnt == cif.cmp_a))));

   assign cif.count = count_ff;
   assign cif.level = level_ff;
   assign cif.match_a = match;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         run_q_ff <= 1'b0;
      end else begin
         run_q_ff <= cif.run;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_ff <= '0;
      end else if (cif.run) begin
         if (count_ff == cif.period) begin
            count_ff <= '0;
         end else begin
            count_ff <= count_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         level_ff <= 1'b0;
      end else if (cif.io_load && !cif.run) begin
         level_ff <= cif.io_init;
      end else if (run_q_ff && !cif.run && cif.pwm_mode) begin
         level_ff <= cif.halt_level;
      end else if (match) begin
         case (cif.io_act)
            TPO_ACT_LOW: level_ff <= 1'b0;
            TPO_ACT_HIGH: level_ff <= 1'b1;
            TPO_ACT_TOGGLE: level_ff <= ~level_ff;
            default: level_ff <= level_ff;
         endcase
      end
   end
endmodule : tpo_chan

// ===== design/tpo_top.sv
/*
 Timer pin output block: two paired channels, pin muxing, output disable, A/D triggers,
 and an Avalon-MM register slave.
 Assumes hiz_request is asynchronous to clock; pins resolve their level from pin_oe_n.
*/
`timescale 1ns/1ps
`include "tpo_regs.svh"

module tpo_top
   import tpo_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [`TPO_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [`TPO_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [`TPO_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic hiz_request,
   output logic [`TPO_NPIN-1:0] pin_out,
   output logic [`TPO_NPIN-1:0] pin_oe_n,
   output logic compare_a_adc_trigger,
   output logic adc_start_req
);
   logic wait_ff;
   tpo_word_t readdata_ff;
   logic [1:0] run_ff;
   logic [7:0] mode_ff;
   logic [7:0] ocr_first_ff;
   logic [7:0] ocr_second_ff;
   logic [7:0] ioc_ff [`TPO_NCH];
   tpo_cnt_t gca_ff [`TPO_NCH];
   tpo_cnt_t period_ff;
   tpo_cnt_t dead_ff;
   tpo_cnt_t sub_cnt_ff;
   tpo_cnt_t adca_ff;
   tpo_cnt_t adcb_ff;
   logic [7:0] hiz_first_ff;
   logic [7:0] hiz_second_ff;
   logic [`TPO_NPIN-1:0] pfs_ff;
   logic [`TPO_NPIN-1:0] gpio_ff;
   logic sync1_ff;
   logic sync2_ff;
   logic sync3_ff;
   logic hiz_req_ff;
   logic [`TPO_NPIN-1:0] pin_out_ff;
   logic [`TPO_NPIN-1:0] pin_oe_n_ff;
   logic trig_a_ff;
   logic adc_start_ff;

   tpo_word_t cur_word;
   tpo_word_t nxt_word;
   logic wr_go;
   logic rd_go;
   tpo_mode_t mode;
   logic pwm_mode;
   logic comp_mode;
   logic hiz_active;
   logic hiz_ch [`TPO_NCH];
   tpo_cnt_t cnt [`TPO_NCH];
   logic lvl [`TPO_NCH];
   logic match [`TPO_NCH];
   logic io_load [`TPO_NCH];
   logic io_init [`TPO_NCH];
   logic halt_lvl [`TPO_NCH];

   function automatic tpo_word_t tpo_merge(input tpo_word_t old_w, input tpo_word_t new_w,
         input logic [3:0] be);
      tpo_word_t res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return res;
   endfunction : tpo_merge

   assign mode = tpo_mode_t'(mode_ff[`TPO_MODE_MSB:0]);
   assign comp_mode = (mode == TPO_MODE_COMP);
   assign pwm_mode = comp_mode || (mode == TPO_MODE_RSYNC);
   assign wr_go = avs_write & ~wait_ff;
   assign rd_go = avs_read & wait_ff;
   assign hiz_ch[0] = hiz_first_ff[`TPO_HIZ_EN_BIT] & hiz_req_ff;
   assign hiz_ch[1] = hiz_second_ff[`TPO_HIZ_EN_BIT] & hiz_req_ff;
   assign hiz_active = hiz_ch[0] | hiz_ch[1];

   // Current value of the addressed word, also the base for byte merging
   always_comb begin
      cur_word = '0;
      case (avs_address)
         `TPO_IDX_START_A: cur_word[1:0] = run_ff;
         `TPO_IDX_START: cur_word[1:0] = run_ff;
         `TPO_IDX_MODE: cur_word[7:0] = mode_ff;
         `TPO_IDX_OCR_FIRST: cur_word[7:0] = ocr_first_ff;
         `TPO_IDX_OCR_SECOND: cur_word[7:0] = ocr_second_ff;
         `TPO_IDX_IOC0: cur_word[7:0] = ioc_ff[0];
         `TPO_IDX_IOC1: cur_word[7:0] = ioc_ff[1];
         `TPO_IDX_GCA0: cur_word[`TPO_CNT_W-1:0] = gca_ff[0];
         `TPO_IDX_GCA1: cur_word[`TPO_CNT_W-1:0] = gca_ff[1];
         `TPO_IDX_PERIOD: cur_word[`TPO_CNT_W-1:0] = period_ff;
         `TPO_IDX_CNT0: cur_word[`TPO_CNT_W-1:0] = cnt[0];
         `TPO_IDX_CNT1: cur_word[`TPO_CNT_W-1:0] = cnt[1];
         `TPO_IDX_DEAD: cur_word[`TPO_CNT_W-1:0] = dead_ff;
         `TPO_IDX_HIZ_FIRST: cur_word[7:0] = hiz_first_ff;
         `TPO_IDX_HIZ_SECOND: cur_word[7:0] = hiz_second_ff;
         `TPO_IDX_PFS: cur_word[`TPO_NPIN-1:0] = pfs_ff;
         `TPO_IDX_GPIO: cur_word[`TPO_NPIN-1:0] = gpio_ff;
         `TPO_IDX_STATUS: begin
            cur_word[`TPO_ST_HIZ_BIT] = hiz_active;
            cur_word[`TPO_ST_LVL0_BIT] = lvl[0];
            cur_word[`TPO_ST_LVL1_BIT] = lvl[1];
         end
         `TPO_IDX_ADCA: cur_word[`TPO_CNT_W-1:0] = adca_ff;
         `TPO_IDX_ADCB: cur_word[`TPO_CNT_W-1:0] = adcb_ff;
         default: cur_word = '0;
      endcase
   end

   assign nxt_word = tpo_merge(cur_word, avs_writedata, avs_byteenable);

   // One wait cycle per access; read data captured as waitrequest drops
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wait_ff <= 1'b1;
         readdata_ff <= '0;
      end else begin
         wait_ff <= ~((avs_read | avs_write) & wait_ff);
         if (rd_go) begin
            readdata_ff <= cur_word;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         run_ff <= '0;
      end else if (wr_go && (avs_address == `TPO_IDX_START_A ||
            avs_address == `TPO_IDX_START)) begin
         run_ff <= nxt_word[1:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode_ff <= '0;
         ocr_first_ff <= '0;
         ocr_second_ff <= '0;
         ioc_ff[0] <= '0;
         ioc_ff[1] <= '0;
         gca_ff[0] <= '0;
         gca_ff[1] <= '0;
         period_ff <= `TPO_PERIOD_RST;
         dead_ff <= `TPO_DEAD_RST;
         adca_ff <= '0;
         adcb_ff <= '0;
         hiz_first_ff <= '0;
         hiz_second_ff <= '0;
         pfs_ff <= `TPO_PFS_RST;
         gpio_ff <= '0;
      end else if (wr_go) begin
         case (avs_address)
            `TPO_IDX_MODE: mode_ff <= nxt_word[7:0];
            `TPO_IDX_OCR_FIRST: ocr_first_ff <= nxt_word[7:0];
            `TPO_IDX_OCR_SECOND: ocr_second_ff <= nxt_word[7:0];
            `TPO_IDX_IOC0: ioc_ff[0] <= nxt_word[7:0];
            `TPO_IDX_IOC1: ioc_ff[1] <= nxt_word[7:0];
            `TPO_IDX_GCA0: gca_ff[0] <= nxt_word[`TPO_CNT_W-1:0];
            `TPO_IDX_GCA1: gca_ff[1] <= nxt_word[`TPO_CNT_W-1:0];
            `TPO_IDX_PERIOD: period_ff <= nxt_word[`TPO_CNT_W-1:0];
            `TPO_IDX_DEAD: dead_ff <= nxt_word[`TPO_CNT_W-1:0];
            `TPO_IDX_ADCA: adca_ff <= nxt_word[`TPO_CNT_W-1:0];
            `TPO_IDX_ADCB: adcb_ff <= nxt_word[`TPO_CNT_W-1:0];
            `TPO_IDX_HIZ_FIRST: hiz_first_ff <= nxt_word[7:0];
            `TPO_IDX_HIZ_SECOND: hiz_second_ff <= nxt_word[7:0];
            `TPO_IDX_PFS: pfs_ff <= nxt_word[`TPO_NPIN-1:0];
            `TPO_IDX_GPIO: gpio_ff <= nxt_word[`TPO_NPIN-1:0];
            default: mode_ff <= mode_ff;
         endcase
      end
   end

   // Dead-time sub-counter runs with the second channel in complementary mode
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sub_cnt_ff <= '0;
      end else if (comp_mode && run_ff[1]) begin
         if (sub_cnt_ff == dead_ff) begin
            sub_cnt_ff <= '0;
         end else begin
            sub_cnt_ff <= sub_cnt_ff + 1'b1;
         end
      end
   end

   // Output disable request: three stages, accepted when the last two agree
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
         hiz_req_ff <= 1'b0;
      end else begin
         sync1_ff <= hiz_request;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         if (sync2_ff == sync3_ff) begin
            hiz_req_ff <= sync3_ff;
         end
      end
   end

   generate
      for (genvar c = 0; c < `TPO_NCH; c++) begin : g_ch
         tpo_chan_if cif ();
         assign io_load[c] = wr_go && (avs_address == `TPO_IDX_IOC0 + c) && avs_byteenable[0];
         assign io_init[c] = nxt_word[`TPO_IOC_INIT_BIT];
         assign halt_lvl[c] = ocr_second_ff[`TPO_OCR_SEL_BIT] ? ocr_second_ff[c] :
            ocr_first_ff[c];
         assign cif.run = run_ff[c];
         assign cif.pwm_mode = pwm_mode;
         assign cif.halt_level = halt_lvl[c];
         assign cif.io_load = io_load[c];
         assign cif.io_init = io_init[c];
         assign cif.io_act = tpo_act_t'(ioc_ff[c][`TPO_IOC_ACT_MSB:`TPO_IOC_ACT_LSB]);
         assign cif.cmp_a = gca_ff[c];
         assign cif.period = period_ff;
         assign cif.ext_cnt = cnt[0];
         assign cif.sub_cnt = sub_cnt_ff;
         assign cif.use_ext = comp_mode && (c == 1);
         assign cnt[c] = cif.count;
         assign lvl[c] = cif.level;
         assign match[c] = cif.match_a;
         tpo_chan u_chan (
            .clock(clock),
            .rst(rst),
            .cif(cif)
         );
      end
   endgenerate

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         trig_a_ff <= 1'b0;
         adc_start_ff <= 1'b0;
      end else begin
         trig_a_ff <= match[1];
         adc_start_ff <= run_ff[1] && (cnt[1] == adca_ff || cnt[1] == adcb_ff);
      end
   end

   generate
      for (genvar p = 0; p < `TPO_NPIN; p++) begin : g_pin
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               pin_out_ff[p] <= 1'b0;
               pin_oe_n_ff[p] <= 1'b1;
            end else begin
               pin_out_ff[p] <= pfs_ff[p] ? lvl[p % `TPO_NCH] : gpio_ff[p];
               pin_oe_n_ff[p] <= hiz_ch[p % `TPO_NCH];
            end
         end
      end
   endgenerate

   assign avs_readdata = readdata_ff;
   assign avs_waitrequest = wait_ff;
   assign pin_out = pin_out_ff;
   assign pin_oe_n = pin_oe_n_ff;
   assign compare_a_adc_trigger = trig_a_ff;
   assign adc_start_req = adc_start_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_halt_pwm0;
      $fell(run_ff[0]) && pwm_mode && !io_load[0];
   endsequence

   sequence s_hiz_on;
      hiz_ch[0] && hiz_ch[1];
   endsequence

   chk_stop_holds_count: assert property (
      !run_ff[1] ##1 !run_ff[1] |-> $stable(cnt[1]))
      else $error("counter moved while stopped");

   chk_pwm_halt_level: assert property (
      s_halt_pwm0 |=> lvl[0] == $past(halt_lvl[0]) ##1 pin_out_ff[0] == lvl[0] ||
         !pfs_ff[0])
      else $error("PWM halt level not driven");

   chk_nonpwm_keep_level: assert property (
      !run_ff[0] && !pwm_mode && !io_load[0] |=> $stable(lvl[0]))
      else $error("level changed while stopped");

   chk_io_write_level: assert property (
      io_load[1] && !run_ff[1] |=> lvl[1] == $past(io_init[1]))
      else $error("stopped write did not set level");

   chk_pair_match_first: assert property (
      run_ff[1] && comp_mode && (cnt[0] == gca_ff[1] || sub_cnt_ff == gca_ff[1]) |->
         match[1])
      else $error("second channel missed a pair match");

   chk_trig_follows: assert property (
      match[1] |=> compare_a_adc_trigger ##0 $past(match[1]))
      else $error("compare-A trigger missing");

   chk_hiz_all_pins: assert property (
      s_hiz_on |=> pin_oe_n == '1)
      else $error("pin driven during output disable");

   chk_resume_from_held: assert property (
      $rose(run_ff[0]) && cnt[0] != period_ff |=> cnt[0] == $past(cnt[0]) + 1)
      else $error("counter did not resume from held value");

   chk_halt_then_stable: assert property (
      s_halt_pwm0 ##1 (!io_load[0] && !run_ff[0]) |=> $stable(lvl[0]))
      else $error("halt level not held");
endmodule : tpo_top

// ===== testbench/tpo_power_stage.sv
/*
 Model of the external power stage and A/D converter that sit on the timer pins.
 Assumes it shares the clock and reset of the timer pin output block.
*/
`timescale 1ns/1ps
`include "tpo_regs.svh"

module tpo_power_stage (
   input wire logic clock,
   input wire logic rst,
   input wire logic [`TPO_NPIN-1:0] pin_out,
   input wire logic [`TPO_NPIN-1:0] pin_oe_n,
   input wire logic compare_a_adc_trigger,
   input wire logic adc_start_req,
   output logic [`TPO_NPIN-1:0] pad,
   output int trig_count,
   output int start_count
);
   logic [`TPO_NPIN-1:0] last_ff;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         last_ff <= '0;
      end else begin
         for (int p = 0; p < `TPO_NPIN; p++) begin
            if (!pin_oe_n[p]) begin
               last_ff[p] <= pin_out[p];
            end
         end
      end
   end

   always_comb begin
      for (int p = 0; p < `TPO_NPIN; p++) begin
         pad[p] = pin_oe_n[p] ? ~last_ff[p] : pin_out[p];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         trig_count <= 0;
         start_count <= 0;
      end else begin
         trig_count <= trig_count + int'(compare_a_adc_trigger);
         start_count <= start_count + int'(adc_start_req);
      end
   end
endmodule : tpo_power_stage

// ===== testbench/tpo_top_tb.sv
/*
 Self-checking testbench of the timer pin output block.
 Assumes the design and tpo_power_stage are compiled first.
*/
`timescale 1ns/1ps
`include "tpo_regs.svh"

module tpo_top_tb;
   import tpo_pkg::*;
   logic clock, rst, avs_read, avs_write, avs_waitrequest, hiz_request;
   logic compare_a_adc_trigger, adc_start_req;
   logic [`TPO_ADDR_W-1:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [`TPO_NPIN-1:0] pin_out, pin_oe_n, pad;
   tpo_word_t avs_writedata, avs_readdata, rd, h0, h1, lv, lv2, ex, c, g;
   int trig_count, start_count, err_count, cmp_count, seed, base, n;

   tpo_top dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .hiz_request(hiz_request), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .compare_a_adc_trigger(compare_a_adc_trigger), .adc_start_req(adc_start_req));
   tpo_power_stage stage (.clock(clock), .rst(rst), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .compare_a_adc_trigger(compare_a_adc_trigger), .adc_start_req(adc_start_req),
      .pad(pad), .trig_count(trig_count), .start_count(start_count));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic complete_run;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic chk_val(input string what, input tpo_word_t exp, input tpo_word_t got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk_val

   // Pins 0 and 2 follow the first channel, 1 and 3 the second
   function automatic tpo_word_t exp_halt_pins(input tpo_word_t lv_f, input tpo_word_t lv_s,
         input int sel);
      tpo_word_t e;
      e = sel ? lv_s : lv_f;
      return {28'h0, e[1], e[0], e[1], e[0]};
   endfunction : exp_halt_pins

   // Holds the request until waitrequest is sampled low
   task automatic bus_op(input logic wr, input logic [5:0] idx, input tpo_word_t d);
      @(posedge clock);
      avs_address <= idx;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      rd = avs_readdata;
      if (n >= 40) begin
         err_count++;
         $display("BAD waitrequest exp 0 got %b", avs_waitrequest);
         complete_run();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus_op

   task automatic bus_wr(input logic [5:0] idx, input tpo_word_t d);
      bus_op(1'b1, idx, d);
   endtask : bus_wr

   task automatic bus_rd(input logic [5:0] idx);
      bus_op(1'b0, idx, 32'h0);
   endtask : bus_rd

   task automatic run_ch(input tpo_word_t bits, input int cycles);
      bus_wr(`TPO_IDX_START, bits);
      repeat (cycles) @(posedge clock);
      bus_wr(`TPO_IDX_START, 32'h0);
   endtask : run_ch

   initial begin
      seed = 68418;
      err_count = 0;
      cmp_count = 0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'hf;
      hiz_request = 1'b0;
      rst = 1'b1;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      bus_rd(`TPO_IDX_PFS);
      chk_val("pfs_reset", 32'h0000000f, rd);
      bus_rd(`TPO_IDX_PERIOD);
      chk_val("period_reset", 32'h0000ffff, rd);
      bus_rd(`TPO_IDX_DEAD);
      chk_val("dead_reset", 32'h00000010, rd);
      bus_wr(6'h3f, 32'h12345678);
      bus_rd(6'h3f);
      chk_val("unmapped_read", 32'h0, rd);
      bus_wr(`TPO_IDX_CNT0, 32'h00001234);
      bus_rd(`TPO_IDX_CNT0);
      chk_val("counter_readonly", 32'h0, rd);
      $display("test registers done");

      for (int m = 1; m <= 2; m++) begin
         for (int s = 0; s < 2; s++) begin
            lv = $random(seed) & 32'h3;
            lv2 = $random(seed) & 32'h3;
            ex = s ? lv2 : lv;
            bus_wr(`TPO_IDX_MODE, 32'(m));
            bus_wr(`TPO_IDX_OCR_FIRST, lv);
            bus_wr(`TPO_IDX_OCR_SECOND, lv2 | 32'(s << 7));
            bus_wr(`TPO_IDX_IOC0, {31'h0, ~ex[0]});
            bus_wr(`TPO_IDX_IOC1, {31'h0, ~ex[1]});
            run_ch(32'h3, 20);
            repeat (4) @(posedge clock);
            chk_val("pwm_halt_pins", exp_halt_pins(lv, lv2, s), {28'h0, pad});
         end
      end
      $display("test pwm halt done");

      bus_wr(`TPO_IDX_MODE, 32'h0);
      // Counter keeps its count from the PWM runs: period and compare lie ahead of it
      bus_rd(`TPO_IDX_CNT0);
      bus_wr(`TPO_IDX_PERIOD, rd + 32'h40);
      c = rd + 32'h1 + ($random(seed) & 32'h1f);
      bus_wr(`TPO_IDX_GCA0, c);
      bus_wr(`TPO_IDX_IOC0, 32'h4);
      repeat (3) @(posedge clock);
      chk_val("io_init_low", 32'h0, {31'h0, pad[0]});
      bus_wr(`TPO_IDX_START, 32'h1);
      repeat (80) @(posedge clock);
      chk_val("compare_high", 32'h1, {31'h0, pad[0]});
      bus_wr(`TPO_IDX_IOC0, 32'h0);
      repeat (3) @(posedge clock);
      chk_val("io_write_running", 32'h1, {31'h0, pad[0]});
      bus_wr(`TPO_IDX_START, 32'h0);
      repeat (4) @(posedge clock);
      chk_val("normal_halt_keeps", 32'h1, {31'h0, pad[0]});
      for (int v = 0; v < 2; v++) begin
         bus_wr(`TPO_IDX_IOC0, 32'(1 - v));
         repeat (3) @(posedge clock);
         chk_val("io_write_stopped", 32'(1 - v), {31'h0, pad[0]});
      end
      $display("test normal halt done");

      bus_wr(`TPO_IDX_PERIOD, 32'hffff);
      bus_rd(`TPO_IDX_CNT0);
      h0 = rd;
      repeat (10) @(posedge clock);
      bus_rd(`TPO_IDX_CNT0);
      chk_val("counter_held", h0, rd);
      bus_wr(`TPO_IDX_START_A, 32'h1);
      bus_rd(`TPO_IDX_CNT0);
      chk_val("resume_from_held", 32'h1, {31'h0, (rd > h0) && (rd - h0 < 20)});
      bus_wr(`TPO_IDX_START_A, 32'h0);
      bus_rd(`TPO_IDX_CNT0);
      h0 = rd;
      $display("test run bit done");

      bus_wr(`TPO_IDX_ADCA, 32'hffff);
      bus_wr(`TPO_IDX_ADCB, 32'hffff);
      run_ch(32'h2, 100);
      c = (h0 == 32'h5) ? 32'h6 : 32'h5;
      bus_wr(`TPO_IDX_GCA1, c);
      base = trig_count;
      run_ch(32'h2, 60);
      chk_val("normal_no_trigger", 32'h0, 32'(trig_count - base));
      bus_wr(`TPO_IDX_MODE, 32'h1);
      base = trig_count;
      run_ch(32'h2, 60);
      chk_val("sub_counter_trigger", 32'h1, {31'h0, trig_count > base});
      $display("test compare trigger done");

      bus_wr(`TPO_IDX_MODE, 32'h0);
      for (int k = 0; k < 2; k++) begin
         bus_rd(`TPO_IDX_CNT1);
         bus_wr(k ? `TPO_IDX_ADCB : `TPO_IDX_ADCA, rd + 32'd30);
         base = start_count;
         run_ch(32'h2, 80);
         chk_val("adc_start_once", 32'h1, 32'(start_count - base));
         bus_wr(k ? `TPO_IDX_ADCB : `TPO_IDX_ADCA, 32'hffff);
      end
      $display("test adc start done");

      g = $random(seed) & 32'hf;
      bus_wr(`TPO_IDX_GPIO, g);
      bus_wr(`TPO_IDX_PFS, 32'h5);
      bus_wr(`TPO_IDX_HIZ_FIRST, 32'h1);
      bus_wr(`TPO_IDX_HIZ_SECOND, 32'h1);
      repeat (3) @(posedge clock);
      chk_val("gpio_pins", {30'h0, g[3], g[1]}, {30'h0, pad[3], pad[1]});
      chk_val("driven_before_hiz", 32'h0, {28'h0, pin_oe_n});
      @(posedge clock);
      hiz_request <= 1'b1;
      n = 0;
      while (pin_oe_n !== 4'hf && n < 20) begin
         @(posedge clock);
         n++;
      end
      chk_val("all_pins_float", 32'hf, {28'h0, pin_oe_n});
      bus_rd(`TPO_IDX_STATUS);
      chk_val("hiz_status", 32'h1, rd & 32'h1);
      bus_wr(`TPO_IDX_PFS, 32'hf);
      $display("test output disable done");
      complete_run();
   end
endmodule : tpo_top_tb
